// *** core/auto_reload_timers.sv ***
// auto-reload timers zero, one and two behind an ahb-lite slave
// assumes a single ahb-lite master, word transfers only, one clock hclk
// Functional notes
// R1: timer zero counts low, high is reload
// R2: low wrap sets flag, reloads from high
// R3: enabled timer zero flag raises interrupt
// R4: reload never alters high reload byte
// R5: software preloads low count before enabling
// R6: timer one mirrors timer zero exactly
// R7: count when run and gate/input allow
// R8: timer two is two bytes, one counter
// R9: split bit selects 16 or dual 8-bit
// R10: timer two source: clock, /12, ext/8
// R11: divided oscillator synchronised before counting
// R12: 16-bit wrap loads reload, sets flag
// R13: timer two overflow interrupts when enabled
// R14: low-byte wrap interrupts when also enabled
// R15: flags stay set until software clears
`timescale 1ns/100ps
`default_nettype none
module auto_reload_timers
  import timer_block_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic external_irq_input_zero,
  input wire logic external_irq_input_one,
  input wire logic ext_osc_in,
  output logic irq
);

  localparam int PW = $clog2(PRESCALE_DIV);
  localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE_DIV - 1);

  // bus slave

  logic addr_take; // a valid transfer is offered to this slave
  logic dp_write_reg; // data phase of a write is in progress
  logic dp_read_reg; // data phase of a read is in progress
  logic [7:0] dp_addr_reg; // latched byte offset of the transfer
  logic unused_bits; // address, size and upper write-data bits the slave ignores

  assign addr_take = hsel & hready & htrans[1];
  assign unused_bits = ^{haddr[31:8], hsize, hwdata[31:16]};

  // capture the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write_reg <= 1'b0;
      dp_read_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      dp_write_reg <= addr_take & hwrite;
      dp_read_reg <= addr_take & ~hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // write strobes, active in the data phase
  logic wr_ctrl; // timer_control_register write
  logic wr_t0; // timer zero count/reload write
  logic wr_t1; // timer one count/reload write
  logic wr_t2_count; // timer two counter write
  logic wr_t2_reload; // timer two reload write
  logic wr_t2_ctrl; // timer_two_control_register write
  logic wr_status; // status write, ones clear
  logic wr_mask; // irq_enable_register write
  logic rd_status; // status read, clears all flags

  assign wr_ctrl = dp_write_reg && (dp_addr_reg == OFF_CONTROL);
  assign wr_t0 = dp_write_reg && (dp_addr_reg == OFF_T0);
  assign wr_t1 = dp_write_reg && (dp_addr_reg == OFF_T1);
  assign wr_t2_count = dp_write_reg && (dp_addr_reg == OFF_T2_COUNT);
  assign wr_t2_reload = dp_write_reg && (dp_addr_reg == OFF_T2_RELOAD);
  assign wr_t2_ctrl = dp_write_reg && (dp_addr_reg == OFF_T2_CONTROL);
  assign wr_status = dp_write_reg && (dp_addr_reg == OFF_STATUS);
  assign wr_mask = dp_write_reg && (dp_addr_reg == OFF_MASK);
  assign rd_status = dp_read_reg && (dp_addr_reg == OFF_STATUS);

  // control registers

  logic [CTL_W-1:0] timer_control_register; // run, gate, polarity bits
  logic [T2C_W-1:0] timer_two_control_register; // run, split, source, low irq
  logic [ST_W-1:0] irq_enable_register; // interrupt mask

  // software-written control state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_control_register <= CONTROL_RESET;
      timer_two_control_register <= T2_CONTROL_RESET;
      irq_enable_register <= MASK_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        timer_control_register <= hwdata[CTL_W-1:0];
      end
      if (wr_t2_ctrl)
      begin
        timer_two_control_register <= hwdata[T2C_W-1:0];
      end
      if (wr_mask)
      begin
        irq_enable_register <= hwdata[ST_W-1:0];
      end
    end
  end

  // timers zero and one

  logic [1:0] run_bit; // timer_zero_run_bit and its twin
  logic [1:0] gate_bit; // timer_zero_gate_bit and its twin
  logic [1:0] pol_bit; // external_input_polarity per timer
  logic [1:0] ext_in; // external interrupt inputs per timer
  logic [1:0] t_enable; // counting allowed this cycle
  logic [1:0] t_write; // software writes the timer this cycle
  logic [1:0] t_ovf; // overflow event per timer
  logic [7:0] low_count_reg [2]; // timer_zero_low_count, timer_one_low_count
  logic [7:0] high_reload_reg [2]; // timer_zero_high_reload, timer_one_high_reload
  logic [8:0] t_step [2]; // {wrap, next} per timer

  assign run_bit = {timer_control_register[CTL_T1_RUN], timer_control_register[CTL_T0_RUN]};
  assign gate_bit = {timer_control_register[CTL_T1_GATE], timer_control_register[CTL_T0_GATE]};
  assign pol_bit = {timer_control_register[CTL_T1_POL], timer_control_register[CTL_T0_POL]};
  assign ext_in = {external_irq_input_one, external_irq_input_zero};
  assign t_write = {wr_t1, wr_t0};

  // input counts as active when its level equals the polarity bit
  assign t_enable = run_bit & (~gate_bit | ~(ext_in ^ pol_bit)); // see R7

  assign t_step[0] = step8(low_count_reg[0], high_reload_reg[0]); // see R1
  assign t_step[1] = step8(low_count_reg[1], high_reload_reg[1]); // see R6

  // a wrap that coincides with a software write is dropped with the count
  assign t_ovf[0] = t_enable[0] & t_step[0][8] & ~t_write[0]; // see R2
  assign t_ovf[1] = t_enable[1] & t_step[1][8] & ~t_write[1]; // see R6

  // counting and reload; the high byte changes only by software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        low_count_reg[i] <= BYTE_RESET;
        high_reload_reg[i] <= BYTE_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (t_write[i])
        begin
          // software preload of count and reload
          low_count_reg[i] <= hwdata[7:0]; // see R5
          high_reload_reg[i] <= hwdata[15:8];
        end
        else if (t_enable[i])
        begin
          // reload path leaves high_reload_reg untouched
          low_count_reg[i] <= t_step[i][7:0]; // see R2, R4
        end
      end
    end
  end

  // timer two clock source

  logic [PW-1:0] prescale_reg; // free-running divide-by-twelve counter
  logic div12_tick; // one cycle in twelve
  logic ext_tick; // synchronised oscillator divided by eight
  logic t2_tick; // selected source tick
  t2_source_type t2_source; // decoded source field

  // free-running prescaler for the divided system clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prescale_reg <= '0;
    end
    else
    begin
      prescale_reg <= (prescale_reg == PRESCALE_LAST) ? '0 : prescale_reg + PW'(1);
    end
  end

  assign div12_tick = (prescale_reg == PRESCALE_LAST); // see R10

  // oscillator passes through a two-flop synchroniser before use
  ext_osc_tick #(
    .DIV(EXT_DIV)
  ) u_ext_osc_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_in(ext_osc_in),
    .tick(ext_tick)
  ); // see R11

  assign t2_source = t2_source_type'(timer_two_control_register[T2C_SRC_HI:T2C_SRC_LO]);

  // source select; the spare code stops the timer
  assign t2_tick = (t2_source == SRC_SYS_CLOCK) ? 1'b1 :
                   (t2_source == SRC_DIV12) ? div12_tick :
                   (t2_source == SRC_EXT8) ? ext_tick : 1'b0; // see R10

  // timer two counter

  logic [7:0] timer_two_low_byte; // counter low byte
  logic [7:0] timer_two_high_byte; // counter high byte
  logic [7:0] timer_two_reload_low; // reload low byte
  logic [7:0] timer_two_reload_high; // reload high byte
  logic t2_advance; // timer two steps this cycle
  logic timer_two_split_select; // split into two 8-bit timers
  logic [15:0] t2_count; // both bytes as one counter
  logic [15:0] t2_reload; // both reload bytes
  logic t2_full; // counter at its maximum
  logic [15:0] t2_next16; // next value in 16-bit mode
  logic [8:0] t2_low_step; // split-mode low byte step
  logic [8:0] t2_high_step; // split-mode high byte step
  logic [15:0] t2_next; // next value in the active mode
  logic t2_high_ovf; // high byte (or full) overflow event
  logic t2_low_ovf; // low byte overflow event

  assign timer_two_split_select = timer_two_control_register[T2C_SPLIT];
  assign t2_advance = timer_two_control_register[T2C_RUN] & t2_tick & ~wr_t2_count;
  assign t2_count = {timer_two_high_byte, timer_two_low_byte}; // see R8
  assign t2_reload = {timer_two_reload_high, timer_two_reload_low};
  assign t2_full = (t2_count == WORD_MAX);

  // 16-bit wrap loads the reload pair
  assign t2_next16 = t2_full ? t2_reload : t2_count + 16'h0001; // see R12

  assign t2_low_step = step8(timer_two_low_byte, timer_two_reload_low);
  assign t2_high_step = step8(timer_two_high_byte, timer_two_reload_high);

  // mode select between one 16-bit and two 8-bit timers
  assign t2_next = timer_two_split_select ?
                   {t2_high_step[7:0], t2_low_step[7:0]} : t2_next16; // see R9

  // overflow events in either mode
  assign t2_high_ovf = t2_advance &
                       (timer_two_split_select ? t2_high_step[8] : t2_full); // see R12
  assign t2_low_ovf = t2_advance & (timer_two_low_byte == BYTE_MAX); // see R14

  // timer two counter and reload registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_two_low_byte <= BYTE_RESET;
      timer_two_high_byte <= BYTE_RESET;
      timer_two_reload_low <= BYTE_RESET;
      timer_two_reload_high <= BYTE_RESET;
    end
    else
    begin
      if (wr_t2_count)
      begin
        timer_two_low_byte <= hwdata[7:0];
        timer_two_high_byte <= hwdata[15:8];
      end
      else if (t2_advance)
      begin
        timer_two_low_byte <= t2_next[7:0];
        timer_two_high_byte <= t2_next[15:8];
      end
      if (wr_t2_reload)
      begin
        timer_two_reload_low <= hwdata[7:0];
        timer_two_reload_high <= hwdata[15:8];
      end
    end
  end

  // status flags and interrupt

  logic [ST_W-1:0] status_reg; // sticky overflow flags
  logic [ST_W-1:0] status_set; // events this cycle
  logic [ST_W-1:0] status_clr; // software clears this cycle
  logic [ST_W-1:0] status_next; // next flag value, set wins
  logic [ST_W-1:0] irq_gate; // per-flag interrupt enable
  logic irq_reg; // registered interrupt level
  logic timer_zero_overflow_flag; // flag view for timer zero

  assign status_set = {t2_low_ovf, t2_high_ovf, t_ovf[1], t_ovf[0]};

  // a status read clears all flags, a write clears the ones written
  assign status_clr = (rd_status ? {ST_W{1'b1}} : {ST_W{1'b0}}) |
                      (wr_status ? hwdata[ST_W-1:0] : {ST_W{1'b0}}); // see R15

  // an event in the clearing cycle survives
  assign status_next = (status_reg & ~status_clr) | status_set; // see R15

  // low-byte interrupt needs timer two enable and both low enables
  assign irq_gate = {irq_enable_register[ST_T2L] & irq_enable_register[ST_T2H] &
                     timer_two_control_register[T2C_LOW_IRQ], // see R14
                     irq_enable_register[ST_T2H], // see R13
                     irq_enable_register[ST_T1],
                     irq_enable_register[ST_T0]}; // see R3

  // flags and interrupt level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_reg <= STATUS_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg <= |(status_next & irq_gate); // see R3, R13
    end
  end

  assign timer_zero_overflow_flag = status_reg[ST_T0];
  assign irq = irq_reg;

  // read data

  logic [31:0] rd_mux; // selected register view

  // unmapped offsets read as zero
  assign rd_mux =
    (dp_addr_reg == OFF_CONTROL) ? {26'h0, timer_control_register} :
    (dp_addr_reg == OFF_T0) ? {16'h0, high_reload_reg[0], low_count_reg[0]} :
    (dp_addr_reg == OFF_T1) ? {16'h0, high_reload_reg[1], low_count_reg[1]} :
    (dp_addr_reg == OFF_T2_COUNT) ? {16'h0, t2_count} :
    (dp_addr_reg == OFF_T2_RELOAD) ? {16'h0, t2_reload} :
    (dp_addr_reg == OFF_T2_CONTROL) ? {27'h0, timer_two_control_register} :
    (dp_addr_reg == OFF_STATUS) ? {28'h0, status_reg[3:1], timer_zero_overflow_flag} :
    (dp_addr_reg == OFF_MASK) ? {28'h0, irq_enable_register} : 32'h0000_0000;

  // read data shown only in a read data phase
  assign hrdata = (dp_read_reg | (unused_bits & 1'b0)) ? rd_mux : 32'h0000_0000;

endmodule
`default_nettype wire

// *** inc/timer_block_pkg.sv ***
// constants, types and helper functions shared by the auto-reload timer block
// assumes a 32-bit ahb-lite register bus with word-aligned registers
package timer_block_pkg;

  // register byte offsets, low eight address bits
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_T0 = 8'h04;
  localparam logic [7:0] OFF_T1 = 8'h08;
  localparam logic [7:0] OFF_T2_COUNT = 8'h0c;
  localparam logic [7:0] OFF_T2_RELOAD = 8'h10;
  localparam logic [7:0] OFF_T2_CONTROL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1c;

  // timer_control_register field positions
  localparam int CTL_T0_RUN = 0;
  localparam int CTL_T1_RUN = 1;
  localparam int CTL_T0_GATE = 2;
  localparam int CTL_T1_GATE = 3;
  localparam int CTL_T0_POL = 4;
  localparam int CTL_T1_POL = 5;
  localparam int CTL_W = 6;
  localparam logic [5:0] CONTROL_RESET = 6'h00;

  // timer_two_control_register field positions
  localparam int T2C_RUN = 0;
  localparam int T2C_SPLIT = 1;
  localparam int T2C_SRC_LO = 2;
  localparam int T2C_SRC_HI = 3;
  localparam int T2C_LOW_IRQ = 4;
  localparam int T2C_W = 5;
  localparam logic [4:0] T2_CONTROL_RESET = 5'h00;

  // status and mask field positions
  localparam int ST_T0 = 0;
  localparam int ST_T1 = 1;
  localparam int ST_T2H = 2;
  localparam int ST_T2L = 3;
  localparam int ST_W = 4;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // counter reset and limit values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WORD_MAX = 16'hffff;

  // clock division figures
  localparam int PRESCALE_DIV = 12;
  localparam int EXT_DIV = 8;

  // ahb-lite encodings
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // timer two clock source, field value order 0..3
  typedef enum logic [1:0] {SRC_SYS_CLOCK, SRC_DIV12, SRC_EXT8, SRC_OFF} t2_source_type;

  // one step of an 8-bit auto-reload counter: {wrapped, next count}
  function automatic logic [8:0] step8(input logic [7:0] count, input logic [7:0] reload);
    logic [8:0] result;
    result = {1'b0, count + 8'h01};
    if (count == BYTE_MAX)
    begin
      result = {1'b1, reload};
    end
    return result;
  endfunction

endpackage

// *** core/ext_osc_tick.sv ***
// external oscillator synchroniser and divide-by-eight tick generator
// assumes the oscillator runs below half the system clock rate
`timescale 1ns/100ps
`default_nettype none
module ext_osc_tick
  import timer_block_pkg::*;
#(
  parameter int DIV = EXT_DIV
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_in,
  output logic tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic meta_reg; // first stage, read only by the second
  logic sync_reg; // second stage, safe to use
  logic prev_reg; // delayed copy for edge detection
  logic [CW-1:0] count_reg; // rising edges seen in this period
  logic tick_reg; // one-cycle pulse every DIV edges
  logic rise; // rising edge of the synchronised oscillator

  assign rise = sync_reg & ~prev_reg;

  // two-flop synchroniser plus edge history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= osc_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // divide the synchronised edges by DIV
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= rise && (count_reg == LAST);
      if (rise)
      begin
        count_reg <= (count_reg == LAST) ? '0 : count_reg + CW'(1);
      end
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// *** tb/auto_reload_timers_asserts.sv ***
// checker for the auto-reload timer block, bound to its top module
// assumes hready is tied to hreadyout and only single word transfers
`timescale 1ns/100ps
`default_nettype none
module auto_reload_timers_asserts
  import timer_block_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq
);
  logic dp_valid_reg;  // a data phase is under way
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic [7:0] t0_reload_reg;  // shadows of what software wrote
  logic [7:0] t1_reload_reg;
  logic [15:0] t2_reload_reg;
  logic [5:0] control_reg;
  logic [4:0] t2_control_reg;
  logic [3:0] mask_reg;
  wire logic rd_w = dp_valid_reg && !dp_write_reg;
  wire logic wr_w = dp_valid_reg && dp_write_reg;
  wire logic unmapped_w = rd_w && dp_addr_reg[7:5] != 3'h0 && dp_addr_reg[1:0] == 2'h0;
  // accesses that may legally move the interrupt line
  wire logic touch_w = dp_valid_reg && (dp_addr_reg == OFF_STATUS ||
    (dp_write_reg && (dp_addr_reg == OFF_MASK || dp_addr_reg == OFF_T2_CONTROL)));
  // no source is unmasked
  wire logic quiet_w = mask_reg[2:0] == 3'h0;

  // follow each accepted transfer into its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end
    else
    begin
      dp_valid_reg <= hsel && hready && htrans[1];
      dp_write_reg <= hwrite;
      dp_addr_reg <= haddr[7:0];
    end
  end

  // shadow each write at the edge that ends its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t0_reload_reg <= 8'h00;
      t1_reload_reg <= 8'h00;
      t2_reload_reg <= 16'h0000;
      control_reg <= CONTROL_RESET;
      t2_control_reg <= T2_CONTROL_RESET;
      mask_reg <= MASK_RESET;
    end
    else if (wr_w)
    begin
      if (dp_addr_reg == OFF_T0)
        t0_reload_reg <= hwdata[15:8];
      if (dp_addr_reg == OFF_T1)
        t1_reload_reg <= hwdata[15:8];
      if (dp_addr_reg == OFF_T2_RELOAD)
        t2_reload_reg <= hwdata[15:0];
      if (dp_addr_reg == OFF_CONTROL)
        control_reg <= hwdata[5:0];
      if (dp_addr_reg == OFF_T2_CONTROL)
        t2_control_reg <= hwdata[4:0];
      if (dp_addr_reg == OFF_MASK)
        mask_reg <= hwdata[3:0];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_bus_okay:
    assert property (hresp == HRESP_OKAY && hreadyout)
    else $error("bus answer not okay");
  chk_control_back:
    assert property (rd_w && dp_addr_reg == OFF_CONTROL |-> hrdata[5:0] == control_reg)
    else $error("control readback wrong");
  chk_t0_reload_kept:
    assert property (rd_w && dp_addr_reg == OFF_T0 |-> hrdata[15:8] == t0_reload_reg)
    else $error("timer zero reload changed");
  chk_t1_reload_kept:
    assert property (rd_w && dp_addr_reg == OFF_T1 |-> hrdata[15:8] == t1_reload_reg)
    else $error("timer one reload changed");
  chk_t2_reload_kept:
    assert property (rd_w && dp_addr_reg == OFF_T2_RELOAD |-> hrdata[15:0] == t2_reload_reg)
    else $error("timer two reload changed");
  chk_t2_control_back:
    assert property (rd_w && dp_addr_reg == OFF_T2_CONTROL |-> hrdata[4:0] == t2_control_reg)
    else $error("timer two control readback wrong");
  chk_mask_back:
    assert property (rd_w && dp_addr_reg == OFF_MASK |-> hrdata[3:0] == mask_reg)
    else $error("mask readback wrong");
  chk_unmapped_zero:
    assert property (unmapped_w |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  // a mask or timer two control write reaches the interrupt line one edge after it lands
  chk_flag_sticky:
    assert property (irq && !touch_w && !$past(touch_w) |=> irq)
    else $error("interrupt dropped by itself");
  chk_masked_quiet:
    assert property (quiet_w && $past(quiet_w) && $past(quiet_w, 2) |-> !irq)
    else $error("interrupt raised while masked");
endmodule

bind auto_reload_timers auto_reload_timers_asserts chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .irq(irq)
);
`default_nettype wire

// *** tb/tb_auto_reload_timers.sv ***
// self-checking bench for the auto-reload timer block over ahb-lite
// assumes the checker is bound in from its own file
`timescale 1ns/100ps
`default_nettype none
module tb_auto_reload_timers
  import timer_block_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] gate_in = 2'h0;  // gate inputs of timers zero and one
  logic osc = 1'b0;  // free-running external oscillator
  wire logic hready;
  wire logic hreadyout;
  wire logic [1:0] hresp;
  wire logic [31:0] hrdata;
  wire logic irq;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [7:0] toff;
  // expected timer two counts per clock source after a fixed run
  logic [15:0] src_lo [4] = '{16'h01e8, 16'h010f, 16'h0102, 16'h00fe};
  logic [15:0] src_hi [4] = '{16'h01f8, 16'h0116, 16'h0105, 16'h00fe};

  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  always #21 osc = ~osc;

  auto_reload_timers dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_irq_input_zero(gate_in[0]), .external_irq_input_one(gate_in[1]),
    .ext_osc_in(osc), .irq(irq)
  );

  // print the counts and the verdict, then stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts whose exact phase is free are checked against a window
  task automatic check_range(input logic [31:0] got, input logic [31:0] lo,
    input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(a, 1'b1, d);
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    bus_xfer(a, 1'b0, 32'h00000000);
    check(rd, exp);
  endtask

  // bounded wait for the interrupt line to rise
  task automatic wait_irq(input int limit);
    int n = 0;
    while (irq !== 1'b1 && n < limit)
    begin
      @(posedge hclk);
      n++;
    end
    check(32'(irq), 32'h1);
    if (irq !== 1'b1)
      end_of_test();
  endtask

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // every register starts at zero, one place past the map reads zero
    for (int i = 0; i < 9; i++)
      read_check(8'(i * 4), 32'h0);
    for (int t = 0; t < 2; t++)
    begin
      toff = (t == 1) ? OFF_T1 : OFF_T0;
      // count from a preloaded start, no wrap yet
      bus_write(toff, 32'h0000f000);
      bus_write(OFF_CONTROL, 32'h1 << t);
      repeat (8) @(posedge hclk);
      bus_write(OFF_CONTROL, 32'h0);
      bus_xfer(toff, 1'b0, 32'h0);
      check_range(rd, 32'h0000f007, 32'h0000f00d);
      read_check(OFF_STATUS, 32'h0);
      // wrap while masked: flag set, interrupt stays low
      bus_write(toff, 32'h0000f0fd);
      bus_write(OFF_CONTROL, 32'h1 << t);
      repeat (20) @(posedge hclk);
      check(32'(irq), 32'h0);
      bus_write(OFF_CONTROL, 32'h0);
      bus_xfer(toff, 1'b0, 32'h0);
      check_range(rd, 32'h0000f0f0, 32'h0000f0ff);
      read_check(OFF_STATUS, 32'h1 << t);
      read_check(OFF_STATUS, 32'h0);
      // wrap unmasked: interrupt holds until a write clears the flag
      bus_write(OFF_MASK, 32'h1 << t);
      bus_write(toff, 32'h0000f0fd);
      bus_write(OFF_CONTROL, 32'h1 << t);
      wait_irq(20);
      bus_write(OFF_CONTROL, 32'h0);
      repeat (10) @(posedge hclk);
      check(32'(irq), 32'h1);
      bus_write(OFF_STATUS, 32'h1 << t);
      @(posedge hclk);
      check(32'(irq), 32'h0);
      read_check(OFF_STATUS, 32'h0);
      bus_write(OFF_MASK, 32'h0);
      // gate and polarity table: k bit 0 says whether it counts
      for (int k = 0; k < 4; k++)
      begin
        gate_in[t] <= k[0] ^ k[1];
        bus_write(toff, 32'h0000f010);
        bus_write(OFF_CONTROL, ((32'h5 | {31'h0, ~k[1]} << 4)) << t);
        repeat (12) @(posedge hclk);
        bus_write(OFF_CONTROL, 32'h0);
        bus_xfer(toff, 1'b0, 32'h0);
        if (k[0])
          check_range(rd, 32'h0000f01b, 32'h0000f021);
        else
          check(rd, 32'h0000f010);
      end
    end
    // timer two from each clock source
    bus_write(OFF_T2_RELOAD, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      bus_write(OFF_T2_COUNT, 32'h000000fe);
      bus_write(OFF_T2_CONTROL, (s << 2) | 1);
      repeat (240) @(posedge hclk);
      bus_write(OFF_T2_CONTROL, 32'h0);
      bus_xfer(OFF_T2_COUNT, 1'b0, 32'h0);
      check_range(rd, {16'h0, src_lo[s]}, {16'h0, src_hi[s]});
    end
    bus_xfer(OFF_STATUS, 1'b0, 32'h0);
    // sixteen-bit wrap reloads the whole word and interrupts
    bus_write(OFF_T2_RELOAD, 32'h0000fff0);
    bus_write(OFF_T2_COUNT, 32'h0000fffd);
    bus_write(OFF_MASK, 32'h4);
    bus_write(OFF_T2_CONTROL, 32'h1);
    wait_irq(20);
    bus_write(OFF_T2_CONTROL, 32'h0);
    bus_xfer(OFF_T2_COUNT, 1'b0, 32'h0);
    check_range(rd, 32'h0000fff0, 32'h0000ffff);
    read_check(OFF_T2_RELOAD, 32'h0000fff0);
    read_check(OFF_STATUS, 32'hc);
    // low-byte wrap interrupts only with its own enable
    bus_write(OFF_T2_RELOAD, 32'h0);
    bus_write(OFF_MASK, 32'hc);
    for (int e = 1; e >= 0; e--)
    begin
      bus_write(OFF_T2_COUNT, 32'h000000f8);
      bus_write(OFF_T2_CONTROL, (e << 4) | 1);
      if (e == 1)
        wait_irq(30);
      else
        repeat (30) @(posedge hclk);
      check(32'(irq), 32'(e[0]));
      bus_write(OFF_T2_CONTROL, 32'h0);
      read_check(OFF_STATUS, 32'h8);
    end
    // split mode: both bytes wrap on the same tick, each from its own reload
    bus_write(OFF_T2_RELOAD, 32'h0000a0b0);
    bus_write(OFF_T2_COUNT, 32'h0000fdfd);
    bus_write(OFF_T2_CONTROL, 32'h13);
    wait_irq(20);
    bus_write(OFF_T2_CONTROL, 32'h0);
    bus_xfer(OFF_T2_COUNT, 1'b0, 32'h0);
    check_range({24'h0, rd[7:0]}, 32'h000000b0, 32'h000000bf);
    check({24'h0, rd[15:8] - 8'ha0}, {24'h0, rd[7:0] - 8'hb0});
    read_check(OFF_STATUS, 32'hc);
    end_of_test();
  end
endmodule
`default_nettype wire
